// *** hw/dnp_pkg.sv ***
// Contract
// - Hit/miss uses programmed page size, not DRAM's
// - Page bits follow page size and port width
// - 2 KB page: 9 lines+4 strobes at 32-bit
// - Set mask bits drop address bits from matching
// - Control value 57h: 8-bit, 1 KB, burst, R/W
// - Page size steers row/column pin multiplexing
// - Normal mode: fresh row then column every time
// - Row, write strobe, row strobe, column, column strobe
// - Nonburst if size fits port; starts with start strobe
// - Wait for bank's row precharge before starting
// - Other bank never waits for precharge
// - Fastest transfer three clocks; timing register slows
// - Read and write timing identical, data direction differs
// - First clock: row, write strobe, size, start strobe
// - Row strobe, then column address, then column strobe
// - Internal acknowledge one clock before completion
// - Completion: capture data, negate ack and strobes
// - Same-bank follow-on starts two clocks after end
// - Page hit compares bits 31 down to 9+code
`default_nettype none
package dnp_pkg;
	// Register byte addresses on the AXI4-Lite slave
	localparam logic [7:0] ADDR_TIMING = 8'h00;
	localparam logic [7:0] ADDR_CTRL0  = 8'h04;
	localparam logic [7:0] ADDR_CTRL1  = 8'h08;
	localparam logic [7:0] ADDR_MASK0  = 8'h0C;
	localparam logic [7:0] ADDR_MASK1  = 8'h10;
	localparam logic [7:0] ADDR_BASE0  = 8'h14;
	localparam logic [7:0] ADDR_BASE1  = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1C;
	localparam logic [31:0] REG_RST    = 32'h0000_0000;
	// Bank control fields
	localparam int CTRL_WE_BIT   = 0;
	localparam int CTRL_RE_BIT   = 1;
	localparam int CTRL_BURST_BIT = 2;
	localparam int CTRL_FPM_BIT  = 3;
	localparam int CTRL_PS_LSB   = 4;
	localparam int CTRL_PORT_LSB = 6;
	// Timing fields: extra clocks beyond the fastest setting
	localparam int TIM_RP_LSB  = 0;
	localparam int TIM_RCD_LSB = 2;
	localparam int TIM_CAS_LSB = 4;
	localparam logic [1:0] PORT_32 = 2'h0;
	localparam logic [1:0] PORT_8  = 2'h1;
	localparam logic [1:0] PORT_16 = 2'h2;
	localparam logic [1:0] PAGE_512 = 2'h0;
	localparam logic [1:0] PAGE_1K  = 2'h1;
	localparam logic [1:0] PAGE_2K  = 2'h2;
	localparam logic [1:0] SIZ_LONG = 2'h0;
	localparam logic [1:0] SIZ_BYTE = 2'h1;
	localparam logic [1:0] SIZ_WORD = 2'h2;
	localparam logic [1:0] SIZ_LINE = 2'h3;
	localparam logic [31:0] BANK_CMP_BITS = 32'hFFFE_0000;
	localparam int ROW_LSB  = 9;
	localparam int ROW_W    = 19;
	localparam int PAGE_LSB_MIN = 9;
	// Precharge load: 1.5 clocks rounds to two idle clocks between end and restart
	localparam logic [2:0] PRECH_LOAD_BASE = 3'h1;
	localparam int NUM_BANKS = 2;

	typedef struct packed {
		logic [31:0]                 timing;
		logic [NUM_BANKS-1:0][31:0]  ctrl;
		logic [NUM_BANKS-1:0][31:0]  mask;
		logic [NUM_BANKS-1:0][31:0]  base;
	} dnp_cfg_s;

	typedef struct packed {
		logic [31:0] addr;
		logic        write;
		logic [1:0]  size;
		logic [31:0] wdata;
	} dnp_req_s;
endpackage : dnp_pkg
`default_nettype wire

// *** hw/dnp_precharge.sv ***
`default_nettype none
// Per-bank row precharge timers; a bank is busy while its count is nonzero
module dnp_precharge (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [dnp_pkg::NUM_BANKS-1:0] load,
	input  wire logic [2:0]                    load_val,
	output logic      [dnp_pkg::NUM_BANKS-1:0] busy
);
	import dnp_pkg::*;

	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			logic [2:0] cnt_reg;
			logic [2:0] cnt_next;
			// Only the bank just closed reloads; the others run down on their own
			assign cnt_next = load[b] ? load_val : (cnt_reg != 3'h0) ? cnt_reg - 3'h1 : cnt_reg;
			always_ff @(posedge aclk) begin
				if (!aresetn) cnt_reg <= 3'h0;
				else cnt_reg <= cnt_next;
			end
			assign busy[b] = (cnt_reg != 3'h0);
		end
	endgenerate
endmodule : dnp_precharge
`default_nettype wire

// *** hw/dnp_axil_regs.sv ***
`default_nettype none
// AXI4-Lite register slave; unmapped or read-only writes answer SLVERR
module dnp_axil_regs (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [31:0]       status,
	output dnp_pkg::dnp_cfg_s      cfg
);
	import dnp_pkg::*;

	logic [7:0]       aw_addr_reg;
	logic             aw_full_reg;
	logic [31:0]      w_data_reg;
	logic [3:0]       w_strb_reg;
	logic             w_full_reg;
	logic [6:0][31:0] regs_reg;
	logic             do_write;
	logic [2:0]       w_idx;
	logic             w_ok;
	logic             r_ok;

	// Address byte 1C is status (read only); everything past it is unmapped
	assign w_idx = aw_addr_reg[4:2];
	assign w_ok = (aw_addr_reg[7:5] == 3'h0) && (aw_addr_reg[1:0] == 2'h0) && (w_idx != 3'h7);
	assign r_ok = (s_axi_araddr[7:5] == 3'h0) && (s_axi_araddr[1:0] == 2'h0);
	assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
	assign cfg = '{timing: regs_reg[0], ctrl: {regs_reg[2], regs_reg[1]},
		mask: {regs_reg[4], regs_reg[3]}, base: {regs_reg[6], regs_reg[5]}};

	// Address and data are taken in either order; response once both are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			regs_reg <= {7{REG_RST}};
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_reg <= s_axi_awaddr;
				aw_full_reg <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				w_full_reg <= 1'b1;
			end
			if (do_write) begin
				for (int i = 0; i < 4; i++) begin
					if (w_ok && w_strb_reg[i]) regs_reg[w_idx][8*i +: 8] <= w_data_reg[8*i +: 8];
				end
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= w_ok ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Reads answer one clock after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= r_ok ? 2'h0 : 2'h2;
			s_axi_rdata <= !r_ok ? 32'h0000_0000 :
				(s_axi_araddr[4:2] == 3'h7) ? status : regs_reg[s_axi_araddr[4:2]];
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : dnp_axil_regs
`default_nettype wire

// *** hw/dnp_ctrl.sv ***
// Implementation choices: the register addresses and the AXI4-Lite register port.
`default_nettype none
// Normal-mode DRAM controller: two banks, nonburst transfers, page sizing
module dnp_ctrl (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	// AXI4-Lite register slave
	input  wire logic [7:0]                 s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [7:0]                 s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	// Core request side
	input  wire logic                       core_req_valid,
	input  wire dnp_pkg::dnp_req_s          core_req,
	output logic                            core_req_ready,
	output logic                            core_err,
	output logic                            transfer_ack_internal,
	output logic [31:0]                     core_rdata,
	output logic                            core_rdata_valid,
	// DRAM pins; dram_addr bit 0 is address pin 9
	output logic [dnp_pkg::ROW_W-1:0]       dram_addr,
	output logic [dnp_pkg::NUM_BANKS-1:0]   ras_n,
	output logic [3:0]                      cas_n,
	output logic                            dram_write_strobe,
	output logic                            transfer_start_n,
	output logic [1:0]                      transfer_size_code,
	input  wire logic [31:0]                dram_data_in,
	output logic [31:0]                     dram_data_out,
	output logic                            dram_data_oe_n
);
	import dnp_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_ROW, ST_RAS, ST_CAS} dnp_state_e;

	////////////////////////////////////////////////////////////////////////////
	// Decode functions

	// Bank match over the unmasked compare bits; bank must allow some access
	function automatic logic bank_match(input logic [31:0] addr, input logic [31:0] base,
		input logic [31:0] mask, input logic [31:0] ctrl);
		logic [31:0] diff;
		diff = (addr ^ base) & BANK_CMP_BITS & ~mask;
		return (diff == 32'h0000_0000) && (ctrl[CTRL_RE_BIT] || ctrl[CTRL_WE_BIT]);
	endfunction : bank_match

	// Operand fits the port: one DRAM cycle, no burst
	function automatic logic fits_port(input logic [1:0] port, input logic [1:0] size);
		logic ok;
		ok = 1'b0;
		unique case (port)
			PORT_8:  ok = (size == SIZ_BYTE);
			PORT_16: ok = (size == SIZ_BYTE) || (size == SIZ_WORD);
			PORT_32: ok = (size != SIZ_LINE);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : fits_port

	// Lowest address bit that lies inside a page for this port width
	function automatic int page_lsb(input logic [1:0] port);
		return (port == PORT_32) ? 2 : (port == PORT_16) ? 1 : 0;
	endfunction : page_lsb

	// Column word: page bits packed from pin (9+page code) upward, rest keep row
	function automatic logic [ROW_W-1:0] col_mux(input logic [31:0] addr,
		input logic [1:0] ps, input logic [1:0] port);
		logic [ROW_W-1:0] col;
		int lo;
		int n;
		int bottom;
		col = addr[ROW_LSB +: ROW_W];
		lo = page_lsb(port);
		bottom = int'(ps);
		n = PAGE_LSB_MIN + int'(ps) - lo;
		for (int i = 0; i < ROW_W; i++) begin
			if (i >= bottom && i < bottom + n) col[i] = addr[lo + i - bottom];
		end
		return col;
	endfunction : col_mux

	// Byte lanes, big endian: strobe 0 serves the top byte lane
	function automatic logic [3:0] lane_mask(input logic [1:0] port, input logic [1:0] size,
		input logic [1:0] a);
		logic [3:0] m;
		m = 4'h0;
		unique case (port)
			PORT_8:  m = 4'h1;
			PORT_16: m = (size == SIZ_WORD) ? 4'h3 : (a[0] ? 4'h2 : 4'h1);
			PORT_32: m = (size == SIZ_LONG) ? 4'hF :
				(size == SIZ_WORD) ? (a[1] ? 4'hC : 4'h3) : (4'h1 << a);
			default: m = 4'h0;
		endcase
		return m;
	endfunction : lane_mask

	// Right-justify read data taken from the port's lanes
	function automatic logic [31:0] read_align(input logic [31:0] din, input logic [1:0] port,
		input logic [1:0] size, input logic [1:0] a);
		logic [1:0] off;
		logic [31:0] r;
		off = (port == PORT_32) ? a : (port == PORT_16) ? {1'b0, a[0]} : 2'h0;
		unique case (size)
			SIZ_BYTE: r = {24'h00_0000, din[8*(3-int'(off)) +: 8]};
			SIZ_WORD: r = {16'h0000, (off[1] ? din[15:0] : din[31:16])};
			default:  r = din;
		endcase
		return r;
	endfunction : read_align

	// Page hit over address bits 31 down to 9 plus the page code
	function automatic logic page_hit(input logic [31:0] a, input logic [31:0] b,
		input logic [1:0] ps);
		logic [31:0] m;
		m = 32'hFFFF_FE00 << ps;
		return ((a ^ b) & m) == 32'h0000_0000;
	endfunction : page_hit

	////////////////////////////////////////////////////////////////////////////
	// Registers and precharge timers

	dnp_cfg_s              cfg;
	logic [31:0]           status;
	logic [NUM_BANKS-1:0]  prech_busy;
	logic [NUM_BANKS-1:0]  prech_load;
	logic [2:0]            prech_val;

	dnp_axil_regs u_regs (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.status        (status),
		.cfg           (cfg)
	);

	dnp_precharge u_prech (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.load     (prech_load),
		.load_val (prech_val),
		.busy     (prech_busy)
	);

	////////////////////////////////////////////////////////////////////////////
	// Request decode

	dnp_state_e       state_reg;
	dnp_state_e       state_next;
	logic [1:0]       wcnt_reg;
	logic [1:0]       wcnt_next;
	dnp_req_s         req_reg;
	logic             bank_reg;
	logic [1:0]       port_reg;
	logic [1:0]       ps_reg;
	logic [NUM_BANKS-1:0][31:0] open_row_reg;
	logic [NUM_BANKS-1:0]       open_vld_reg;
	logic             last_hit_reg;
	logic             last_bank_reg;

	logic             hit0;
	logic             hit1;
	logic             any_hit;
	logic             sel_bank;
	logic [31:0]      sel_ctrl;
	logic [1:0]       sel_port;
	logic [1:0]       sel_ps;
	logic             sel_allowed;
	logic             legal;
	logic             idle;
	logic             accept;
	logic             reject;
	logic             last_cas;

	// Bank 0 wins if software overlaps the two banks
	assign hit0 = bank_match(core_req.addr, cfg.base[0], cfg.mask[0], cfg.ctrl[0]);
	assign hit1 = bank_match(core_req.addr, cfg.base[1], cfg.mask[1], cfg.ctrl[1]);
	assign any_hit = hit0 || hit1;
	assign sel_bank = !hit0;
	assign sel_ctrl = cfg.ctrl[sel_bank];
	assign sel_port = sel_ctrl[CTRL_PORT_LSB +: 2];
	assign sel_ps = sel_ctrl[CTRL_PS_LSB +: 2];
	assign sel_allowed = core_req.write ? sel_ctrl[CTRL_WE_BIT] : sel_ctrl[CTRL_RE_BIT];
	assign legal = any_hit && sel_allowed && fits_port(sel_port, core_req.size) && (sel_ps != 2'h3);
	assign idle = (state_reg == ST_IDLE);
	// A legal request stalls while a transfer runs or its own bank is precharging
	assign accept = core_req_valid && idle && legal && !prech_busy[sel_bank];
	// Bursts, misses and denied accesses are consumed with an error pulse
	assign reject = core_req_valid && idle && !legal;
	assign core_req_ready = accept || reject;
	assign core_err = reject;
	assign last_cas = (state_reg == ST_CAS) && (wcnt_reg == 2'h0);
	// Acknowledge stands in the clock before completion
	assign transfer_ack_internal = last_cas;

	////////////////////////////////////////////////////////////////////////////
	// Transfer sequencer: row, row strobe, column strobe, then back to idle

	always_comb begin
		state_next = state_reg;
		wcnt_next = wcnt_reg;
		unique case (state_reg)
			ST_IDLE: if (accept) state_next = ST_ROW;
			ST_ROW: begin
				state_next = ST_RAS;
				wcnt_next = cfg.timing[TIM_RCD_LSB +: 2];
			end
			ST_RAS: begin
				if (wcnt_reg == 2'h0) begin
					state_next = ST_CAS;
					wcnt_next = cfg.timing[TIM_CAS_LSB +: 2];
				end else begin
					wcnt_next = wcnt_reg - 2'h1;
				end
			end
			ST_CAS: begin
				if (wcnt_reg == 2'h0) state_next = ST_IDLE;
				else wcnt_next = wcnt_reg - 2'h1;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
			wcnt_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			wcnt_reg <= wcnt_next;
		end
	end

	// Latch the request and its bank settings at acceptance
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_reg <= '0;
			bank_reg <= 1'b0;
			port_reg <= PORT_32;
			ps_reg <= PAGE_512;
		end else if (accept) begin
			req_reg <= core_req;
			bank_reg <= sel_bank;
			port_reg <= sel_port;
			ps_reg <= sel_ps;
		end
	end

	// Precharge starts as the strobes negate; timing register adds clocks
	assign prech_load = last_cas ? (NUM_BANKS'(1) << bank_reg) : '0;
	assign prech_val = PRECH_LOAD_BASE + {1'b0, cfg.timing[TIM_RP_LSB +: 2]};

	////////////////////////////////////////////////////////////////////////////
	// Pin drive, registered from the next state so pins change on the edge

	logic             in_row;
	logic             in_ras;
	logic             in_cas;
	logic [ROW_W-1:0] row_word;
	logic [ROW_W-1:0] col_word;
	logic [31:0]      wr_lanes;

	assign in_row = (state_next == ST_ROW);
	assign in_ras = (state_next == ST_RAS) || (state_next == ST_CAS);
	assign in_cas = (state_next == ST_CAS);
	assign row_word = in_row ? core_req.addr[ROW_LSB +: ROW_W] : req_reg.addr[ROW_LSB +: ROW_W];
	assign col_word = col_mux(req_reg.addr, ps_reg, port_reg);
	// Replicated operand lands on whichever lanes the strobes select
	assign wr_lanes = (req_reg.size == SIZ_BYTE) ? {4{req_reg.wdata[7:0]}} :
		(req_reg.size == SIZ_WORD) ? {2{req_reg.wdata[15:0]}} : req_reg.wdata;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			transfer_start_n <= 1'b1;
			ras_n <= '1;
			cas_n <= 4'hF;
			dram_write_strobe <= 1'b1;
			transfer_size_code <= SIZ_LONG;
			dram_addr <= '0;
		end else begin
			transfer_start_n <= !in_row;
			// Row strobe of the open bank only; the other bank keeps precharging
			ras_n <= in_ras ? ~(NUM_BANKS'(1) << bank_reg) : '1;
			cas_n <= in_cas ? ~lane_mask(port_reg, req_reg.size, req_reg.addr[1:0]) : 4'hF;
			if (in_row) begin
				dram_addr <= row_word;
				dram_write_strobe <= !core_req.write;
				transfer_size_code <= core_req.size;
			end else if (in_ras) begin
				dram_addr <= col_word;
			end else begin
				dram_write_strobe <= 1'b1;
			end
		end
	end

	// Writes drive data from the row strobe phase on; reads leave the bus to the DRAM
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dram_data_out <= 32'h0000_0000;
			dram_data_oe_n <= 1'b1;
		end else begin
			dram_data_out <= wr_lanes;
			dram_data_oe_n <= !(in_ras && req_reg.write);
		end
	end

	// Read data taken at the completing edge, no later: bus is released then
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_rdata <= 32'h0000_0000;
			core_rdata_valid <= 1'b0;
		end else begin
			core_rdata_valid <= last_cas && !req_reg.write;
			if (last_cas && !req_reg.write) begin
				core_rdata <= read_align(dram_data_in, port_reg, req_reg.size,
					req_reg.addr[1:0]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Page tracking for status; normal mode still opens a fresh row each time

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			open_row_reg <= '0;
			open_vld_reg <= '0;
			last_hit_reg <= 1'b0;
			last_bank_reg <= 1'b0;
		end else if (accept) begin
			last_hit_reg <= open_vld_reg[sel_bank] &&
				page_hit(core_req.addr, open_row_reg[sel_bank], sel_ps);
			open_row_reg[sel_bank] <= core_req.addr;
			open_vld_reg[sel_bank] <= 1'b1;
			last_bank_reg <= sel_bank;
		end
	end

	// Status: busy, last bank, last page hit, per-bank precharge, state
	assign status = {25'h0, state_reg, prech_busy, last_hit_reg, last_bank_reg, !idle};
endmodule : dnp_ctrl
`default_nettype wire

// *** sim/dnp_dram_model.sv ***
`default_nettype none
// Far-side DRAM: answers reads while a column strobe is low
module dnp_dram_model #(
	parameter logic [7:0] RD_BYTE = 8'h5A
) (
	input  wire logic        aclk,
	input  wire logic [3:0]  cas_n,
	input  wire logic        dram_write_strobe,
	output logic      [31:0] dram_data_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] idle_pat = 32'h0F0F_0F0F;
	// Released bus keeps changing, so a late sample never matches by luck
	always @(posedge aclk) idle_pat <= ~idle_pat;
	// Drives on reads only; the controller owns the bus on writes
	assign dram_data_in = (cas_n != 4'hF && dram_write_strobe) ? {4{RD_BYTE}} : idle_pat;
endmodule : dnp_dram_model
`default_nettype wire

// *** sim/dnp_ctrl_checker.sv ***
`default_nettype none
// Pin sequencing of normal-mode transfers
module dnp_ctrl_checker (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              core_req_valid,
	input wire dnp_pkg::dnp_req_s core_req,
	input wire logic              core_req_ready,
	input wire logic              core_err,
	input wire logic              transfer_ack_internal,
	input wire logic              core_rdata_valid,
	input wire logic [1:0]        ras_n,
	input wire logic [3:0]        cas_n,
	input wire logic              dram_write_strobe,
	input wire logic              transfer_start_n,
	input wire logic [1:0]        transfer_size_code,
	input wire logic              dram_data_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////
	start_pulse_a: assert property ($fell(transfer_start_n) |=> transfer_start_n)
		else $error("start strobe too long");
	start_fields_a: assert property (core_req_valid && core_req_ready && !core_err |=>
		!transfer_start_n && transfer_size_code == $past(core_req.size)
		&& dram_write_strobe == !$past(core_req.write)) else $error("bad start cycle");
	ras_follows_a: assert property (!transfer_start_n |=> ras_n != 2'h3 && cas_n == 4'hF)
		else $error("row strobe late");
	cas_in_ras_a: assert property (cas_n != 4'hF |-> ras_n != 2'h3)
		else $error("column strobe without row");
	ack_end_a: assert property (transfer_ack_internal |-> cas_n != 4'hF ##1
		(ras_n == 2'h3 && cas_n == 4'hF && !transfer_ack_internal)) else $error("bad end");
	read_capture_a: assert property (transfer_ack_internal && dram_write_strobe |=>
		core_rdata_valid) else $error("read data not returned");
	precharge_gap_a: assert property ($rose(ras_n[0]) |-> ras_n[0] [*3])
		else $error("precharge too short");
	drive_on_write_a: assert property (!dram_data_oe_n |-> !dram_write_strobe)
		else $error("bus driven on read");
	reset_idle_a: assert property (disable iff (1'b0) !aresetn |=> ras_n == 2'h3
		&& cas_n == 4'hF && transfer_start_n && dram_write_strobe) else $error("reset state");
	// Main scenarios reached
	cover property (transfer_ack_internal && dram_write_strobe);
	cover property (transfer_ack_internal && !dram_write_strobe);
	cover property (core_req_ready && core_err);
endmodule : dnp_ctrl_checker
bind dnp_ctrl dnp_ctrl_checker u_dnp_ctrl_checker (.*);
`default_nettype wire

// *** sim/dnp_ctrl_tb.sv ***
`default_nettype none
module dnp_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import dnp_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, core_err;
	logic core_req_valid, core_req_ready, transfer_ack_internal, core_rdata_valid, e;
	logic dram_write_strobe, transfer_start_n, dram_data_oe_n;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, core_rdata, dram_data_in, dram_data_out, d;
	logic [3:0] s_axi_wstrb, cas_n;
	logic [1:0] s_axi_bresp, s_axi_rresp, ras_n, transfer_size_code, r;
	logic [ROW_W-1:0] dram_addr, col;
	logic [ROW_W-1:0] rq[$];
	dnp_req_s core_req;
	int failures, cmp_count, cyc;
	int sq[$];
	dnp_ctrl u_dnp_ctrl (.*);
	dnp_dram_model u_dnp_dram_model (.*);
	////////////////////////////////////////////////
	// Clock, and a log of start cycles with the row shown then
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (ras_n != 2'h3 && cas_n == 4'hF) col = dram_addr;
		if (transfer_start_n === 1'b0) begin
			sq.push_back(cyc);
			rq.push_back(dram_addr);
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	task automatic print_verdict;
		$display("comparisons=%0d mismatches=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	// Bus tasks: ready is lowered, then an edge passes, so no re-entry clash
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : axw
	task automatic axr(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		{d, r} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : axr
	// Request stays valid on return; the caller follows it or drops it
	task automatic cq(input logic [31:0] a, input logic w, input logic [1:0] s);
		core_req <= '{a, w, s, 32'h0000_00A5};
		core_req_valid <= 1'b1;
		do @(posedge aclk); while (core_req_ready !== 1'b1);
		e = core_err;
	endtask : cq
	task automatic wait_rd;
		core_req_valid <= 1'b0;
		do @(posedge aclk); while (core_rdata_valid !== 1'b1);
	endtask : wait_rd
	////////////////////////////////////////////////
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, core_req_valid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		core_req = '0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		chk(32'({ras_n, cas_n, transfer_start_n, dram_write_strobe}), 32'hFF);
		cq(32'h0000_1235, 1'b0, SIZ_BYTE);
		core_req_valid <= 1'b0;
		chk(32'(e), 32'h1);
		$display("reset test done");
		// Both banks 8-bit, 1 KB; only the masks and bases differ, page size kept
		axw(ADDR_CTRL0, 32'h57);
		axr(ADDR_CTRL0);
		chk(d, 32'h57);
		axw(ADDR_MASK0, 32'h001E_0000);
		axr(ADDR_MASK0);
		chk(d, 32'h001E_0000);
		axw(ADDR_CTRL1, 32'h57);
		axw(ADDR_MASK1, 32'h000E_0000);
		axw(ADDR_BASE1, 32'h0040_0000);
		axw(ADDR_STATUS, 32'h1);
		chk(32'(r), 32'h2);
		axr(8'h20);
		chk(32'(r), 32'h2);
		$display("register test done");
		cq(32'h0000_1235, 1'b0, SIZ_BYTE);
		wait_rd();
		chk(core_rdata, 32'h5A);
		chk(32'(rq[$]), 32'h9);
		chk(32'(col), 32'h46B);
		cq(32'h0000_1234, 1'b0, SIZ_LONG);
		core_req_valid <= 1'b0;
		chk(32'(e), 32'h1);
		$display("read test done");
		// Same bank twice, then the other bank at once
		sq.delete();
		cq(32'h0000_1234, 1'b0, SIZ_BYTE);
		cq(32'h0000_0400, 1'b0, SIZ_BYTE);
		cq(32'h0040_0100, 1'b0, SIZ_BYTE);
		wait_rd();
		chk(32'(sq[1] - sq[0]), 32'h5);
		chk(32'(sq[2] - sq[1]), 32'h4);
		$display("back to back test done");
		// One extra precharge clock stretches the same-bank gap
		axw(ADDR_TIMING, 32'h1);
		sq.delete();
		cq(32'h0000_0010, 1'b1, SIZ_BYTE);
		cq(32'h0000_0020, 1'b1, SIZ_BYTE);
		core_req_valid <= 1'b0;
		do @(posedge aclk); while (dram_data_oe_n !== 1'b0);
		chk(dram_data_out, 32'hA5A5_A5A5);
		chk(32'(dram_write_strobe), 32'h0);
		do @(posedge aclk); while (transfer_ack_internal !== 1'b1);
		chk(32'(sq[1] - sq[0]), 32'h6);
		$display("write test done");
		print_verdict();
	end
	// Watchdog cuts a hang short
	initial begin
		#100000;
		failures++;
		print_verdict();
	end
endmodule : dnp_ctrl_tb
`default_nettype wire
